/* File: core/adc_conversion_control.sv */
// adc_conversion_control: register file, sequencer and successive
// approximation logic for an 8-bit bipolar converter.
// assumes an analog comparator and trial dac outside, synchronous inputs,
// and a register master that never issues read and write together.
//
// How it works
// - valid result: high nibble, low to shadow
// - low register loads from shadow on high read
// - conversion end raises done request
// - two-cycle acquisition, sample held until end
// - whole conversion takes ten clock cycles
// - bit seven set when above virtual ground
// - negative magnitudes in ones' complement
// - two select bits choose converter input
// - reset gives continuous mode, reference pad
// - reference select one picks internal supply
// - one-shot bit: zero continuous, one single
// - continuous go repeats conversions at 3.2kHz
// - clearing go finishes current conversion first
// - continuous: request per conversion, masked default
// - single: one conversion, go auto-clears, request
`timescale 1ns/1ps

module adc_conversion_control
    import adc_ctrl_pkg::*;
#(
    parameter int CONT_PERIOD = CONT_PERIOD_CYC          // cycles between starts
) (
    input  wire logic                          clk_sys,       // system clock
    input  wire logic                          rst_n,         // sync reset, active low
    input  wire logic [adc_ctrl_pkg::ADDR_W-1:0] reg_addr,    // register index
    input  wire logic [adc_ctrl_pkg::DATA_W-1:0] reg_wdata,   // write data
    input  wire logic                          reg_wr,        // write strobe
    input  wire logic                          reg_rd,        // read strobe
    output logic      [adc_ctrl_pkg::DATA_W-1:0] reg_rdata,   // read data, next cycle
    input  wire logic                          cmp_above,     // comparator: vin above trial
    output logic                               sample_hold,   // high while sampling
    output logic      [7:0]                    dac_code,      // trial code to dac
    output logic                               input_select_a, // mux select a
    output logic                               input_select_b, // mux select b
    output logic                               reference_source_select, // 1: internal
    output logic                               oscillator_supervisor_disable, // sys ctl
    output logic                               logic_supervisor_disable, // sys ctl
    output logic                               conversion_active, // converting
    output logic                               conversion_done_irq, // request to cpu
    input  wire logic                          irq_ack        // controller acknowledge
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam int WAIT_CYC = CONT_PERIOD - CONV_CYC;    // idle gap between conversions
    localparam int CNT_W    = $clog2(CONT_PERIOD + 1);   // counter width

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,                               // no conversion
        ST_ACQ  = 4'b0010,                               // sampling input
        ST_SAR  = 4'b0100,                               // bit decisions
        ST_GAP  = 4'b1000                                // continuous spacing
    } seq_state_t;

    seq_state_t              state_r;                    // sequencer state
    seq_state_t              state_nxt;                  // next state
    logic [CNT_W-1:0]        cnt_r;                      // acquisition / gap counter
    logic [CNT_W-1:0]        cnt_nxt;                    // next count
    logic [7:0]              code_r;                     // current trial code
    logic [7:0]              code_nxt;                   // next trial code
    logic [7:0]              bit_r;                      // bit under test, one-hot
    logic [7:0]              bit_nxt;                    // next bit under test
    logic [2:0]              ctl_r;                      // single, sel_b, sel_a
    logic                    go_r;                       // convert_go
    logic                    go_nxt;                     // next convert_go
    logic [DATA_W-1:0]       high_r;                     // result high nibble
    logic [DATA_W-1:0]       low_r;                      // visible low nibble
    logic [DATA_W-1:0]       shadow_r;                   // hidden low nibble
    logic [DATA_W-1:0]       sc3_r;                      // system control 3
    logic                    mask_r;                     // conversion_irq_mask
    logic                    pend_r;                     // pending done request
    logic [DATA_W-1:0]       rdata_r;                    // registered read data
    logic [DATA_W-1:0]       rd_mux;                     // selected read value

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire wr_ctl   = reg_wr && (reg_addr == ADC_CONTROL_IDX);      // control write
    wire wr_low   = reg_wr && (reg_addr == ADC_RESULT_LOW_IDX);   // low write
    wire wr_high  = reg_wr && (reg_addr == ADC_RESULT_HIGH_IDX);  // high write
    wire wr_sc3   = reg_wr && (reg_addr == SYSTEM_CONTROL_3_IDX); // sys ctl write
    wire wr_irq   = reg_wr && (reg_addr == ADC_IRQ_CONTROL_IDX);  // mask write
    wire rd_high  = reg_rd && (reg_addr == ADC_RESULT_HIGH_IDX);  // high read

    // ------------------------------------------------------------
    // sequencer helpers
    // ------------------------------------------------------------
    wire single_mode = ctl_r[CTL_SINGLE_BIT];
    wire last_bit    = (state_r == ST_SAR) && bit_r[0];            // final decision
    wire conv_done   = last_bit;                                   // result valid
    // keep the tested bit if input above trial, then try the next bit
    wire [7:0] decided = cmp_above ? code_r : (code_r & ~bit_r);

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        code_nxt  = code_r;
        bit_nxt   = bit_r;
        case (state_r)
            ST_IDLE: begin                                 // wait for go
                if (go_r) begin
                    state_nxt = ST_ACQ;
                    cnt_nxt   = '0;
                end
            end
            ST_ACQ: begin                                  // sample for two cycles
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == CNT_W'(ACQ_CYC - 1)) begin
                    state_nxt = ST_SAR;
                    code_nxt  = SAR_FIRST;
                    bit_nxt   = SAR_FIRST;
                end
            end
            ST_SAR: begin                                  // one bit per cycle
                code_nxt = decided | (bit_r >> 1);
                bit_nxt  = bit_r >> 1;
                if (bit_r[0]) begin                        // conversion finished
                    code_nxt = decided;
                    cnt_nxt  = '0;
                    // continuous with go still set waits for the next slot
                    if (!single_mode && go_r) begin
                        state_nxt = ST_GAP;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_GAP: begin                                  // spacing to 3.2kHz
                cnt_nxt = cnt_r + 1'b1;
                if (!go_r) begin                           // stopped by software
                    state_nxt = ST_IDLE;
                end else if (cnt_r == CNT_W'(WAIT_CYC - 1)) begin
                    state_nxt = ST_ACQ;
                    cnt_nxt   = '0;
                end
            end
            default: begin                                 // illegal code recovers
                state_nxt = ST_IDLE;
                cnt_nxt   = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r   <= '0;
            code_r  <= SAR_FIRST;
            bit_r   <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            code_r  <= code_nxt;
            bit_r   <= bit_nxt;
        end
    end

    // ------------------------------------------------------------
    // convert_go: written by software, cleared at single-mode end
    // ------------------------------------------------------------
    always_comb begin
        go_nxt = go_r;
        if (conv_done && single_mode) begin
            go_nxt = 1'b0;
        end
        if (wr_ctl) begin
            go_nxt = reg_wdata[CTL_GO_BIT];                // write wins
        end
    end

    // ------------------------------------------------------------
    // control and system control 3
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctl_r <= ADC_CONTROL_RST[2:0];
            go_r  <= ADC_CONTROL_RST[CTL_GO_BIT];
            sc3_r <= SYSTEM_CONTROL_3_RST;
        end else begin
            go_r <= go_nxt;
            if (wr_ctl) begin
                ctl_r <= reg_wdata[2:0];
            end
            if (wr_sc3) begin
                sc3_r <= reg_wdata & 4'hb;                 // bit 2 reserved
            end
        end
    end

    // ------------------------------------------------------------
    // result registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            high_r   <= ADC_RESULT_RST;
            shadow_r <= ADC_RESULT_RST;
            low_r    <= ADC_RESULT_RST;
        end else begin
            if (conv_done) begin
                high_r   <= decided[7:4];
                shadow_r <= decided[3:0];
            end else if (wr_high) begin
                high_r <= reg_wdata;                       // software write
            end
            if (rd_high) begin
                low_r <= shadow_r;
            end else if (wr_low) begin
                low_r <= reg_wdata;                        // software write
            end
        end
    end

    // ------------------------------------------------------------
    // done request: set wins over acknowledge
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pend_r <= 1'b0;
            mask_r <= IRQ_MASK_RST;
        end else begin
            if (conv_done) begin
                pend_r <= 1'b1;
            end else if (irq_ack) begin
                pend_r <= 1'b0;
            end
            if (wr_irq) begin
                mask_r <= reg_wdata[IRQ_MASK_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        case (reg_addr)
            ADC_CONTROL_IDX:      rd_mux = {conversion_active, ctl_r};
            ADC_RESULT_LOW_IDX:   rd_mux = low_r;
            ADC_RESULT_HIGH_IDX:  rd_mux = high_r;
            SYSTEM_CONTROL_3_IDX: rd_mux = sc3_r;
            ADC_IRQ_CONTROL_IDX:  rd_mux = {2'b00, pend_r, mask_r};
            default:              rd_mux = 4'h0;           // unmapped reads zero
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_r <= 4'h0;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 4'h0;             // valid only after a read
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata                     = rdata_r;
    assign sample_hold                   = (state_r == ST_ACQ);
    assign dac_code                      = code_r;
    assign conversion_active             = (state_r == ST_ACQ) || (state_r == ST_SAR);
    assign input_select_a                = ctl_r[CTL_SEL_A_BIT];
    assign input_select_b                = ctl_r[CTL_SEL_B_BIT];
    assign reference_source_select       = sc3_r[SC3_REF_BIT];
    assign oscillator_supervisor_disable = sc3_r[SC3_OSC_BIT];
    assign logic_supervisor_disable      = sc3_r[SC3_LOGIC_BIT];
    assign conversion_done_irq           = pend_r && !mask_r;

endmodule

/* File: core/adc_ctrl_pkg.sv */
// adc_ctrl_pkg: register map, field positions, reset values and timing
// counts for the converter control block.
// assumes a 4-bit register port and a 200 MHz system clock.
package adc_ctrl_pkg;

    // ------------------------------------------------------------
    // register port geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 3;                        // register index width
    localparam int DATA_W = 4;                        // register data width

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADC_CONTROL_IDX      = 3'h0; // mode and input select
    localparam logic [ADDR_W-1:0] ADC_RESULT_LOW_IDX   = 3'h1; // visible low nibble
    localparam logic [ADDR_W-1:0] ADC_RESULT_HIGH_IDX  = 3'h2; // high nibble
    localparam logic [ADDR_W-1:0] SYSTEM_CONTROL_3_IDX = 3'h3; // reference select
    localparam logic [ADDR_W-1:0] ADC_IRQ_CONTROL_IDX  = 3'h4; // mask and pending

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL_SEL_A_BIT   = 0;               // input_select_a
    localparam int CTL_SEL_B_BIT   = 1;               // input_select_b
    localparam int CTL_SINGLE_BIT  = 2;               // one-shot select
    localparam int CTL_GO_BIT      = 3;               // convert_go / conversion_active
    localparam int SC3_LOGIC_BIT   = 0;               // logic_supervisor_disable
    localparam int SC3_OSC_BIT     = 1;               // oscillator_supervisor_disable
    localparam int SC3_REF_BIT     = 3;               // reference_source_select
    localparam int IRQ_MASK_BIT    = 0;               // conversion_irq_mask
    localparam int IRQ_PEND_BIT    = 1;               // pending request (read only)

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] ADC_CONTROL_RST      = 4'h0; // continuous, reference pad
    localparam logic [DATA_W-1:0] ADC_RESULT_RST       = 4'h0; // result nibbles
    localparam logic [DATA_W-1:0] SYSTEM_CONTROL_3_RST = 4'h0; // external reference
    localparam logic              IRQ_MASK_RST         = 1'b1; // masked by default

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 200_000_000;     // system clock rate
    localparam int ACQ_CYC         = 2;               // acquisition cycles
    localparam int CONV_CYC        = 10;              // full conversion cycles
    localparam int CONT_RATE_HZ    = 3200;            // continuous repeat rate
    localparam int CONT_PERIOD_CYC = CLK_HZ / CONT_RATE_HZ; // cycles per repeat
    localparam logic [7:0] SAR_FIRST = 8'h80;         // first trial: sign bit

endpackage

/* File: verif/adc_ctrl_chk.sv */
// adc_ctrl_chk: port-level checks for the converter control block.
// assumes binding onto adc_conversion_control, one clock, sync reset.
`timescale 1ns/1ps
module adc_ctrl_chk (
    input wire logic                            clk_sys,        // system clock
    input wire logic                            rst_n,          // sync reset, active low
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] reg_addr,       // register index
    input wire logic [adc_ctrl_pkg::DATA_W-1:0] reg_wdata,      // write data
    input wire logic                            reg_wr,         // write strobe
    input wire logic                            sample_hold,    // acquisition window
    input wire logic [7:0]                      dac_code,       // trial code
    input wire logic                            input_select_a, // mux select a
    input wire logic                            input_select_b, // mux select b
    input wire logic                            reference_source_select, // reference
    input wire logic                            conversion_active, // converting
    input wire logic                            conversion_done_irq, // request
    input wire logic                            irq_ack         // acknowledge
);
    import adc_ctrl_pkg::*;
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    AST_ACQ_TWO: assert property ($rose(sample_hold) |=> sample_hold ##1 !sample_hold)
        else $error("acquisition not two cycles");
    AST_ACQ_AT_START: assert property ($rose(conversion_active) |-> sample_hold)
        else $error("conversion does not open with acquisition");
    AST_CONV_TEN: assert property ($rose(conversion_active) |->
        conversion_active[*8] ##1 conversion_active[*2] ##1 !conversion_active)
        else $error("conversion not ten cycles");
    AST_FIRST_TRIAL: assert property ($fell(sample_hold) |->
        conversion_active && dac_code == SAR_FIRST)
        else $error("first trial is not the sign bit");
    AST_IRQ_HOLD: assert property (conversion_done_irq && !irq_ack && !reg_wr
        |=> conversion_done_irq)
        else $error("request dropped without acknowledge");
    AST_ACK_CLEAR: assert property (irq_ack && !conversion_active |=> !conversion_done_irq)
        else $error("acknowledge did not clear request");
    AST_SEL_WRITE: assert property (reg_wr && reg_addr == ADC_CONTROL_IDX |=>
        {input_select_b, input_select_a} == $past(reg_wdata[1:0]))
        else $error("input select not taken from write");
    AST_REF_WRITE: assert property (reg_wr && reg_addr == SYSTEM_CONTROL_3_IDX |=>
        reference_source_select == $past(reg_wdata[SC3_REF_BIT]))
        else $error("reference select not taken from write");
    AST_RESET_DEFAULT: assert property ($rose(rst_n) |->
        !input_select_a && !input_select_b && !reference_source_select && !conversion_active)
        else $error("wrong state after reset");
    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    cov_conv: cover property ($fell(conversion_active));
    cov_irq: cover property ($rose(conversion_done_irq));
    cov_ack: cover property (irq_ack && conversion_done_irq);
endmodule

bind adc_conversion_control adc_ctrl_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .sample_hold(sample_hold),
    .dac_code(dac_code), .input_select_a(input_select_a), .input_select_b(input_select_b),
    .reference_source_select(reference_source_select), .conversion_active(conversion_active),
    .conversion_done_irq(conversion_done_irq), .irq_ack(irq_ack));

/* File: verif/adc_front_model.sv */
// adc_front_model: ideal input mux, sample and hold, and comparator.
// assumes codes in offset form, 8'h80 at virtual ground.
`timescale 1ns/1ps
module adc_front_model #(
    parameter logic [7:0] REF_EXT_CODE = 8'hff,  // pad against its own reference
    parameter logic [7:0] REF_INT_CODE = 8'hc0   // pad against supply, plain default
) (
    input wire logic       clk_sys,                 // system clock
    input wire logic       sample_hold,             // acquisition window
    input wire logic [7:0] dac_code,                // trial code
    input wire logic       input_select_a,          // mux select a
    input wire logic       input_select_b,          // mux select b
    input wire logic       reference_source_select, // 1: internal supply
    input wire logic [7:0] code_a,                  // first input level
    input wire logic [7:0] code_b,                  // second input level
    output logic           cmp_above                // held input above trial
);
    logic [7:0] vin;     // selected input
    logic [7:0] held_r;  // sampled input
    // input mux; sign bit set above ground, ones' complement below
    assign vin = ({input_select_b, input_select_a} == 2'b00) ?
        (reference_source_select ? REF_INT_CODE : REF_EXT_CODE) :
        ({input_select_b, input_select_a} == 2'b01) ? code_a :
        ({input_select_b, input_select_a} == 2'b10) ? code_b : 8'h80;
    // sample during acquisition, hold until next one
    always @(posedge clk_sys) begin
        if (sample_hold) held_r <= vin;
    end
    assign cmp_above = (held_r >= dac_code);
endmodule

/* File: verif/tb_top.sv */
// tb_top: self-checking bench for the converter control block.
// assumes adc_front_model on the far side and a shortened repeat period.
`timescale 1ns/1ps
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
    import adc_ctrl_pkg::*;
    localparam int         CONT_P  = 20;        // short repeat period
    localparam logic [7:0] REF_INT = 8'hc0;     // model pad level on supply
    logic              clk_sys   = 1'b0;        // system clock
    logic              rst_n     = 1'b0;        // sync reset
    logic [ADDR_W-1:0] reg_addr  = '0;          // register index
    logic [DATA_W-1:0] reg_wdata = '0;          // write data
    logic              reg_wr    = 1'b0;        // write strobe
    logic              reg_rd    = 1'b0;        // read strobe
    logic              irq_ack   = 1'b0;        // acknowledge
    logic [7:0]        code_a    = 8'h00;       // first input level
    logic [7:0]        code_b    = 8'h00;       // second input level
    logic [DATA_W-1:0] reg_rdata;               // read data
    logic [7:0]        dac_code, expv;          // trial code, expected result
    logic [3:0]        low_vis, sc;             // visible low, sysctl value
    logic              cmp_above, sample_hold, sel_a, sel_b, ref_sel, active, irq;
    logic              osc_dis, lgc_dis;        // supervisor disable outputs
    int                failures, tests_run, cycles, act_len, gap, rises, n0;
    bit                cont_chk, gap_ok, prev_act;
    always #2.5 clk_sys = ~clk_sys;
    adc_conversion_control #(.CONT_PERIOD(CONT_P)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cmp_above(cmp_above), .sample_hold(sample_hold),
        .dac_code(dac_code), .input_select_a(sel_a), .input_select_b(sel_b),
        .reference_source_select(ref_sel), .oscillator_supervisor_disable(osc_dis),
        .logic_supervisor_disable(lgc_dis), .conversion_active(active),
        .conversion_done_irq(irq), .irq_ack(irq_ack));
    adc_front_model #(.REF_INT_CODE(REF_INT)) u_front (.clk_sys(clk_sys),
        .sample_hold(sample_hold), .dac_code(dac_code), .input_select_a(sel_a),
        .input_select_b(sel_b), .reference_source_select(ref_sel), .code_a(code_a),
        .code_b(code_b), .cmp_above(cmp_above));
    // ------------------------------------------------------------
    // bus tasks, reference model, verdict
    // ------------------------------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        `CHECK(reg_rdata, exp)
    endtask
    task automatic ack();
        @(posedge clk_sys);
        irq_ack <= 1'b1;
        @(posedge clk_sys);
        irq_ack <= 1'b0;
        #1;
    endtask
    task automatic wait_act(input logic v); // bounded wait on busy flag
        int n;
        n = 0;
        while (active !== v && n < 200) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n == 200) failures++;
    endtask
    function automatic logic [7:0] exp_code(int ch, logic rs); // ideal result
        case (ch)
            0: return rs ? REF_INT : 8'hff;
            1: return code_a;
            2: return code_b;
            default: return 8'h80;
        endcase
    endfunction
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // monitor: conversion length, repeat spacing, timeout
    always @(posedge clk_sys) begin
        gap++;
        if (rst_n && active === 1'b1) begin
            act_len++;
            if (!prev_act) begin // conversion start
                if (gap_ok && cont_chk) `CHECK(gap, CONT_P)
                gap_ok = cont_chk;
                gap = 0;
                rises++;
            end
        end else if (act_len != 0) begin
            `CHECK(act_len, 10)
            act_len = 0;
        end
        prev_act = (active === 1'b1);
        cycles++;
        if (cycles == 3000) begin
            failures++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h01a5));
        code_a = 8'($urandom);
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ADC_CONTROL_IDX, ADC_CONTROL_RST);
        rd(ADC_RESULT_LOW_IDX, 4'h0);
        rd(ADC_RESULT_HIGH_IDX, 4'h0);
        rd(SYSTEM_CONTROL_3_IDX, 4'h0);
        rd(ADC_IRQ_CONTROL_IDX, 4'h1);
        rd(3'h7, 4'h0);
        cont_chk = 1;
        wr(ADC_CONTROL_IDX, 4'h9); // continuous, first input
        repeat (3 * CONT_P + 5) @(posedge clk_sys);
        `CHECK(irq, 1'b0)
        `CHECK(rises >= 3, 1'b1)
        wait_act(1'b1);
        wr(ADC_CONTROL_IDX, 4'h1); // clear go mid conversion
        cont_chk = 0;
        wait_act(1'b0);
        n0 = rises;
        repeat (3 * CONT_P) @(posedge clk_sys);
        `CHECK(rises, n0)
        rd(ADC_RESULT_HIGH_IDX, code_a[7:4]);
        rd(ADC_RESULT_LOW_IDX, code_a[3:0]);
        low_vis = code_a[3:0];
        wr(ADC_RESULT_HIGH_IDX, 4'h5);
        rd(ADC_RESULT_HIGH_IDX, 4'h5);
        wr(ADC_RESULT_LOW_IDX, 4'ha);
        low_vis = 4'ha;
        wr(ADC_IRQ_CONTROL_IDX, 4'h0);
        `CHECK(irq, 1'b1)
        ack();
        `CHECK(irq, 1'b0)
        for (int ch = 0; ch < 4; ch++) begin
            @(posedge clk_sys);
            code_a <= 8'($urandom);
            code_b <= 8'($urandom);
            sc = 4'($urandom);
            wr(SYSTEM_CONTROL_3_IDX, sc);
            rd(SYSTEM_CONTROL_3_IDX, sc & 4'hb);
            `CHECK({ref_sel, osc_dis, lgc_dis}, {sc[3], sc[1:0]})
            wr(ADC_CONTROL_IDX, {2'b11, 2'(ch)});
            rd(ADC_CONTROL_IDX, {2'b11, 2'(ch)});
            wait_act(1'b0);
            `CHECK(irq, 1'b1)
            expv = exp_code(ch, sc[3]);
            rd(ADC_RESULT_LOW_IDX, low_vis);
            rd(ADC_RESULT_HIGH_IDX, expv[7:4]);
            rd(ADC_RESULT_LOW_IDX, expv[3:0]);
            low_vis = expv[3:0];
            rd(ADC_CONTROL_IDX, {2'b01, 2'(ch)});
            ack();
            `CHECK(irq, 1'b0)
        end
        give_verdict();
    end
endmodule
